// *** kgp_pkg.sv ***
// constants for the keypad shared gpio ports
package kgp_pkg;
   localparam int addr_width = 8;
   localparam int port3_width = 3;
   localparam int port2_width = 2;
   localparam logic [7:0] port3_data_offset = 8'h0A;
   localparam logic [7:0] port2_data_offset = 8'h0B;
   localparam logic [7:0] port2_direction_offset = 8'h0F;
   localparam logic [7:0] port3_direction_offset = 8'h0E;
   localparam logic [2:0] port3_direction_reset = 3'h0;
   localparam logic [1:0] port2_direction_reset = 2'h0;
   localparam logic [7:0] read_unmapped_value = 8'h00;
endpackage

// *** kgp_ports.sv ***
// two gpio ports whose pins are shared with keyboard wake-up inputs
//
// Functional notes
// - first port has three pins with latch and direction bit each, wake-capable.
// - second port has two pins with latch and direction bit each, wake-capable.
// - reset never alters first port data latches.
// - reset never alters second port data latches.
// - wake enable on first port pin forces it input, overriding direction.
// - wake enable on second port pin makes it an input.
// - direction one drives latch on pin; zero leaves pin high impedance.
// - reset clears first port direction bits.
// - reset clears second port direction bits.
// - first port data read gives latch where direction is one, pin where it is zero, wake enable aside.
// - second port data read gives latch where direction is one, pin where it is zero, wake enable aside.
// - data writes always update latches regardless of direction.
// - writing latch of a pin with direction zero does not change value read.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module kgp_ports
#(
   parameter int p3_width = kgp_pkg::port3_width,
   parameter int p2_width = kgp_pkg::port2_width
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [kgp_pkg::addr_width-1:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   input wire logic [p3_width-1:0] key_wake_enable3,
   input wire logic [p2_width-1:0] key_wake_enable2,
   input wire logic [p3_width-1:0] port3_pin_in,
   output logic [p3_width-1:0] port3_pin_out,
   output logic [p3_width-1:0] port3_pin_oe,
   input wire logic [p2_width-1:0] port2_pin_in,
   output logic [p2_width-1:0] port2_pin_out,
   output logic [p2_width-1:0] port2_pin_oe,
   output logic [p3_width-1:0] key_wake_pins3,
   output logic [p2_width-1:0] key_wake_pins2
);
   import kgp_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [p3_width-1:0] port3_direction;
      logic [p2_width-1:0] port2_direction;
      logic [p3_width-1:0] sync3_a;
      logic [p3_width-1:0] sync3_b;
      logic [p2_width-1:0] sync2_a;
      logic [p2_width-1:0] sync2_b;
      logic [p3_width-1:0] wake3;
      logic [p2_width-1:0] wake2;
      logic [p3_width-1:0] wake_pins3;
      logic [p2_width-1:0] wake_pins2;
      logic [7:0] read_data;
   } kgp_state_type;

   kgp_state_type state;
   kgp_state_type next_state;
   // latches are kept out of the reset struct so that reset cannot touch them
   logic [p3_width-1:0] port3_latch;
   logic [p2_width-1:0] port2_latch;

   function automatic logic [7:0] mix_read(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] pin);
      mix_read = (latch & dir) | (pin & ~dir);
   endfunction

   // one strobe aimed at one register offset
   function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                input logic [7:0] offset);
      hit = strobe && addr == offset;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_state.sync3_a = port3_pin_in;
      next_state.sync3_b = state.sync3_a;
      next_state.sync2_a = port2_pin_in;
      next_state.sync2_b = state.sync2_a;
      next_state.wake3 = key_wake_enable3;
      next_state.wake2 = key_wake_enable2;
      next_state.wake_pins3 = state.sync3_b & state.wake3;
      next_state.wake_pins2 = state.sync2_b & state.wake2;
      if (write_strobe && address == port3_direction_offset)
      begin
         next_state.port3_direction = write_data[p3_width-1:0];
      end
      if (write_strobe && address == port2_direction_offset)
      begin
         next_state.port2_direction = write_data[p2_width-1:0];
      end
      next_state.read_data = read_unmapped_value;
      if (read_strobe)
      begin
         case (address)
            port3_data_offset:
               next_state.read_data = mix_read(8'(port3_latch), 8'(state.port3_direction),
                                               8'(state.sync3_b));
            port2_data_offset:
               next_state.read_data = mix_read(8'(port2_latch), 8'(state.port2_direction),
                                               8'(state.sync2_b));
            port3_direction_offset:
               next_state.read_data = 8'(state.port3_direction);
            port2_direction_offset:
               next_state.read_data = 8'(state.port2_direction);
            default:
               next_state.read_data = read_unmapped_value;
         endcase
      end
      if (reset)
      begin
         next_state.port3_direction = port3_direction_reset;
         next_state.port2_direction = port2_direction_reset;
         next_state.read_data = read_unmapped_value;
         next_state.wake3 = '0;
         next_state.wake2 = '0;
         next_state.wake_pins3 = '0;
         next_state.wake_pins2 = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      state <= next_state;
   end

   // ------------------------------------------------------------
   // data latches
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (hit(write_strobe, address, port3_data_offset))
      begin
         port3_latch <= write_data[p3_width-1:0];
      end
      if (hit(write_strobe, address, port2_data_offset))
      begin
         port2_latch <= write_data[p2_width-1:0];
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   logic [p3_width-1:0] pin3_out;
   logic [p3_width-1:0] pin3_oe;
   logic [p2_width-1:0] pin2_out;
   logic [p2_width-1:0] pin2_oe;

   always_ff @(posedge clk)
   begin
      pin3_oe <= next_state.port3_direction & ~next_state.wake3;
      pin2_oe <= next_state.port2_direction & ~next_state.wake2;
      // undriven pins show zero so nothing unknown leaves the block
      pin3_out <= (hit(write_strobe, address, port3_data_offset) ?
                   write_data[p3_width-1:0] : port3_latch) &
                  next_state.port3_direction & ~next_state.wake3;
      pin2_out <= (hit(write_strobe, address, port2_data_offset) ?
                   write_data[p2_width-1:0] : port2_latch) &
                  next_state.port2_direction & ~next_state.wake2;
   end

   assign read_data = state.read_data;
   assign port3_pin_oe = pin3_oe;
   assign port2_pin_oe = pin2_oe;
   assign port3_pin_out = pin3_out;
   assign port2_pin_out = pin2_out;
   assign key_wake_pins3 = state.wake_pins3;
   assign key_wake_pins2 = state.wake_pins2;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ------------------------------------------------------------
   // reset behaviour
   // ------------------------------------------------------------
   reset_dir3_a: assert property (@(posedge clk) disable iff (1'b0)
      reset
      |=> state.port3_direction == '0)
   else $error("port3 direction not cleared");
   reset_dir2_a: assert property (@(posedge clk) disable iff (1'b0)
      reset
      |=> state.port2_direction == '0)
   else $error("port2 direction not cleared");
   reset_oe3_a: assert property (@(posedge clk) disable iff (1'b0)
      reset
      |=> pin3_oe == '0)
   else $error("port3 pin driven after reset");
   reset_oe2_a: assert property (@(posedge clk) disable iff (1'b0)
      reset
      |=> pin2_oe == '0)
   else $error("port2 pin driven after reset");
   reset_read_a: assert property (@(posedge clk) disable iff (1'b0)
      reset
      |=> read_data == 8'h00)
   else $error("read data not cleared by reset");
   keep_latch3_a: assert property (@(posedge clk) disable iff (1'b0)
      reset && !hit(write_strobe, address, port3_data_offset)
      |=> port3_latch === $past(port3_latch))
   else $error("port3 latch changed by reset");
   keep_latch2_a: assert property (@(posedge clk) disable iff (1'b0)
      reset && !hit(write_strobe, address, port2_data_offset)
      |=> port2_latch === $past(port2_latch))
   else $error("port2 latch changed by reset");
   reset_wake3_a: assert property (@(posedge clk) disable iff (1'b0)
      reset
      |=> key_wake_pins3 == '0)
   else $error("port3 wake pins not cleared");
   reset_wake2_a: assert property (@(posedge clk) disable iff (1'b0)
      reset
      |=> key_wake_pins2 == '0)
   else $error("port2 wake pins not cleared");

   // ------------------------------------------------------------
   // register access
   // ------------------------------------------------------------
   read_p3_a: assert property (
      hit(read_strobe, address, port3_data_offset)
      |=> read_data[2:0] == (($past(port3_latch) & $past(state.port3_direction)) |
                             ($past(state.sync3_b) & ~$past(state.port3_direction))))
   else $error("port3 read wrong");
   read_p3_hi_a: assert property (
      hit(read_strobe, address, port3_data_offset)
      |=> read_data[7:3] == 5'h00)
   else $error("port3 read upper bits set");
   read_p2_mix_a: assert property (
      hit(read_strobe, address, port2_data_offset)
      |=> read_data[1:0] == (($past(port2_latch) & $past(state.port2_direction)) |
                             ($past(state.sync2_b) & ~$past(state.port2_direction))))
   else $error("port2 read wrong");
   read_p2_a: assert property (
      hit(read_strobe, address, port2_data_offset)
      |=> read_data[7:2] == 6'h00)
   else $error("port2 read upper bits set");
   dir3_read_a: assert property (
      hit(read_strobe, address, port3_direction_offset)
      |=> read_data == 8'($past(state.port3_direction)))
   else $error("port3 direction read wrong");
   dir2_high_a: assert property (
      hit(read_strobe, address, port2_direction_offset)
      |=> read_data[7:2] == 6'h00)
   else $error("reserved bits not zero");
   dir2_read_a: assert property (
      hit(read_strobe, address, port2_direction_offset)
      |=> read_data[1:0] == $past(state.port2_direction))
   else $error("port2 direction read wrong");
   dir3_wr_a: assert property (
      hit(write_strobe, address, port3_direction_offset)
      |=> state.port3_direction == $past(write_data[2:0]))
   else $error("port3 direction not written");
   dir2_wr_a: assert property (
      hit(write_strobe, address, port2_direction_offset)
      |=> state.port2_direction == $past(write_data[1:0]))
   else $error("port2 direction not written");
   latch_wr_a: assert property (
      hit(write_strobe, address, port3_data_offset)
      |=> port3_latch == $past(write_data[2:0]))
   else $error("port3 latch not written");
   latch2_wr_a: assert property (
      hit(write_strobe, address, port2_data_offset)
      |=> port2_latch == $past(write_data[1:0]))
   else $error("port2 latch not written");
   idle_read_a: assert property (
      !read_strobe
      |=> read_data == 8'h00)
   else $error("read data not cleared");
   unmapped_read_a: assert property (
      read_strobe && address != port3_data_offset && address != port2_data_offset &&
      address != port3_direction_offset && address != port2_direction_offset
      |=> read_data == read_unmapped_value)
   else $error("unmapped read not zero");

   // ------------------------------------------------------------
   // pin drive and wake-up
   // ------------------------------------------------------------
   drive_dir_a: assert property (
      ##1 pin2_oe == (state.port2_direction & ~state.wake2))
   else $error("port2 drive mismatch");
   drive_dir3_a: assert property (
      ##1 pin3_oe == (state.port3_direction & ~state.wake3))
   else $error("port3 drive mismatch");
   wake_in_a: assert property (
      (state.wake3 & pin3_oe) == '0)
   else $error("wake pin driven");
   wake2_in_a: assert property (
      (state.wake2 & pin2_oe) == '0)
   else $error("port2 wake pin driven");
   wake_pin3_a: assert property (
      ##1 key_wake_pins3 == $past(state.sync3_b & state.wake3))
   else $error("port3 wake pins wrong");
   wake_pin2_a: assert property (
      ##1 key_wake_pins2 == $past(state.sync2_b & state.wake2))
   else $error("port2 wake pins wrong");
   out3_latch_a: assert property (
      pin3_oe != '0
      |-> (port3_pin_out & pin3_oe) == (port3_latch & pin3_oe))
   else $error("port3 pins do not show latch");
   out2_latch_a: assert property (
      pin2_oe != '0
      |-> (port2_pin_out & pin2_oe) == (port2_latch & pin2_oe))
   else $error("port2 pins do not show latch");

   for (genvar i = 0; i < p3_width; i++)
   begin : g_bit3
      bit3_idle_a: assert property (
         !pin3_oe[i]
         |-> port3_pin_out[i] == 1'b0)
      else $error("undriven port3 pin not zero");
   end

   for (genvar i = 0; i < p2_width; i++)
   begin : g_bit2
      bit2_idle_a: assert property (
         !pin2_oe[i]
         |-> port2_pin_out[i] == 1'b0)
      else $error("undriven port2 pin not zero");
   end

   out_cov: cover property (pin3_oe != '0);
   wake_cov: cover property (state.wake2 != '0);
   read_cov: cover property (read_strobe && address == port2_data_offset);
   keep_cov: cover property (reset && state.port3_direction != '0);
   dir_cov: cover property (hit(write_strobe, address, port3_direction_offset));
endmodule

// *** kgp_pins.sv ***
// resolved pin levels seen by the gpio ports
`timescale 1ns/100ps
module kgp_pins
(
   input wire logic [2:0] oe3,
   input wire logic [2:0] out3,
   input wire logic [2:0] ext3,
   input wire logic [1:0] oe2,
   input wire logic [1:0] out2,
   input wire logic [1:0] ext2,
   output logic [2:0] pin3,
   output logic [1:0] pin2
);
   assign pin3 = (oe3 & out3) | (~oe3 & ext3);
   assign pin2 = (oe2 & out2) | (~oe2 & ext2);
endmodule

// *** kgp_ports_tb.sv ***
// self-checking bench for the keypad shared gpio ports
`timescale 1ns/100ps
module kgp_ports_tb;
   import kgp_pkg::*;
   logic clk = 0, reset = 1, write_strobe = 0, read_strobe = 0;
   logic [7:0] address = 8'h00, write_data = 8'h00, read_data;
   logic [2:0] kwe3 = 3'h0, ext3 = 3'h0, p3o, p3e, pin3, kw3;
   logic [1:0] kwe2 = 2'h0, ext2 = 2'h0, p2o, p2e, pin2, kw2;
   int err_count = 0, n_compared = 0;
   kgp_ports u_dut (.clk(clk), .reset(reset), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .key_wake_enable3(kwe3), .key_wake_enable2(kwe2), .port3_pin_in(pin3),
      .port3_pin_out(p3o), .port3_pin_oe(p3e), .port2_pin_in(pin2), .port2_pin_out(p2o),
      .port2_pin_oe(p2e), .key_wake_pins3(kw3), .key_wake_pins2(kw2));
   kgp_pins u_pins (.oe3(p3e), .out3(p3o), .ext3(ext3), .oe2(p2e), .out2(p2o), .ext2(ext2),
      .pin3(pin3), .pin2(pin2));
   initial forever #20 clk = ~clk;
   task check(input logic [7:0] seen, input logic [7:0] exp, input string name);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      #1 check(read_data, exp, "read_data");
   endtask
   task t_input;
      ext3 <= 3'h5;
      ext2 <= 2'h2;
      wr(port3_data_offset, 8'hFF);
      wr(port2_data_offset, 8'hFF);
      repeat (4) @(posedge clk);
      rd(port3_data_offset, 8'h05);
      rd(port2_data_offset, 8'h02);
      check({p3e, p2e}, 5'h00, "oe inputs");
      $display("test input done");
   endtask
   task t_output;
      wr(port3_direction_offset, 8'hFF);
      wr(port2_direction_offset, 8'hFF);
      rd(port3_direction_offset, 8'h07);
      rd(port2_direction_offset, 8'h03);
      check({p3e, p3o, p2e, p2o}, 10'h3FF, "pins out");
      rd(port3_data_offset, 8'h07);
      wr(port3_data_offset, 8'h02);
      rd(port3_data_offset, 8'h02);
      rd(port2_data_offset, 8'h03);
      $display("test output done");
   endtask
   task t_wake;
      @(posedge clk);
      kwe3 <= 3'h7;
      kwe2 <= 2'h3;
      repeat (5) @(posedge clk);
      #1;
      check({p3e, p2e}, 5'h00, "wake oe");
      check({kw3, kw2}, 5'h16, "wake pins");
      @(posedge clk);
      kwe3 <= 3'h0;
      kwe2 <= 2'h0;
      $display("test wake done");
   endtask
   task t_keep;
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      rd(port3_direction_offset, 8'h00);
      rd(port2_direction_offset, 8'h00);
      wr(port3_direction_offset, 8'h07);
      wr(port2_direction_offset, 8'h03);
      rd(port3_data_offset, 8'h02);
      rd(port2_data_offset, 8'h03);
      rd(8'h55, read_unmapped_value);
      $display("test keep done");
   endtask
   task conclude;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #(2000 * 40);
      err_count++;
      conclude;
   end
   initial
   begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rd(port3_direction_offset, 8'h00);
      rd(port2_direction_offset, 8'h00);
      t_input;
      t_output;
      t_wake;
      t_keep;
      conclude;
   end
endmodule
